// ---- verilog/sbs_core.sv ----
// Synchronous burst static memory core, 32K words by 32 bits
// Notes on behaviour
// - Array of 32768 words, 32 bits each
// - Two-bit counter makes burst low address bits
// - Synchronous inputs captured on rising edge only
// - Output drive, standby, order act asynchronously
// - Address loads only on an address strobe
// - Counter steps only when burst step low
// - Writes self-timed after registering address, controls
// - Each lane write enables one byte lane
// - Lane writes honoured only while gate low
// - Full word write low writes all lanes
// - Gate and all lanes low writes full
// - Read after write returns the new data
// - All three selects must be asserted
// - Latency select: pipelined high, flow-through low
// - Order select high gives interleaved order
// - No drive until edge after access start
// - Drivers turn off after a deselect
// - Outputs stay off after write until strobe/step
// - Back-to-back reads through either strobe
// - Interleaved order XORs low bits 01,10,11
// - Linear order increments low bits modulo four
// - Standby turns outputs off, keeps contents
// - Processor strobe starts a read when all three selects are asserted
`timescale 1ns/10ps
`include "sbs_defines.svh"
module sbs_core #(
  parameter int WORDS = `SBS_WORDS,
  parameter int AW = `SBS_ADDR_W,
  parameter int DW = `SBS_DATA_W,
  parameter int LANES = `SBS_LANES
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Clears the cycle state and the output-valid tracking
  input wire logic [AW-1:0] addr, // Word address
  input wire logic [DW-1:0] dataIn, // Data bus level seen at the pins
  output logic [DW-1:0] dataOut, // Read data driven onto the bus
  output logic dataOe_n, // Low while the core drives the bus
  input wire logic chipSel_n, // Primary select, active low
  input wire logic secondarySel_n, // Secondary select, active low
  input wire logic secondary_select, // Secondary select, active high
  input wire logic proc_addr_strobe_n, // Processor address strobe
  input wire logic ctrl_addr_strobe_n, // Controller address strobe
  input wire logic burst_step_n, // Burst advance
  input wire logic [LANES-1:0] lane_write_n, // Per-lane write
  input wire logic lane_write_gate_n, // Gate for lane writes
  input wire logic full_word_write_n, // Full word write
  input wire logic outDrive_n, // Output enable, asynchronous
  input wire logic standby_request, // Standby, asynchronous
  input wire logic latency_select, // 1 pipelined, 0 flow-through
  input wire logic burstOrder // 1 interleaved, 0 linear
);
  localparam int LW = DW / LANES;

  logic [DW-1:0] mem [WORDS];
  logic [AW-1:0] addrHi_reg;
  logic selected_reg;
  logic [LANES-1:0] wrLanes;
  logic [LANES-1:0] wrLanes_reg;
  logic [DW-1:0] wrData_reg;
  logic [AW-1:0] wrAddr_reg;
  logic [1:0] lowBits;
  logic [AW-1:0] curAddr;
  logic anyStrobe;
  logic procStart;
  logic ctrlStart;
  logic chipOn;
  logic loadAddr;
  logic stepAddr;
  logic [DW-1:0] flowData;
  logic [DW-1:0] pipeData_reg;
  logic readValid_reg;
  logic pipeValid_reg;
  logic readPending_reg;
  logic lastWasWrite_reg;
  sbs_pkg::sbs_cycle_t cycle_reg;
  sbs_pkg::sbs_cycle_t cycle_next;

  assign chipOn = !chipSel_n && !secondarySel_n && secondary_select;
  // Processor strobe is qualified by the primary select only
  assign procStart = !proc_addr_strobe_n && !chipSel_n;
  assign ctrlStart = !ctrl_addr_strobe_n;
  assign loadAddr = procStart || ctrlStart;
  assign anyStrobe = loadAddr || !burst_step_n;
  // Step ignored on the loading edge so the loaded address is used first
  assign stepAddr = !loadAddr && !burst_step_n && selected_reg;

  always_comb
  begin
    if (!full_word_write_n)
      wrLanes = `SBS_FULL_LANES;
    else if (!lane_write_gate_n)
      wrLanes = ~lane_write_n;
    else
      wrLanes = `SBS_NO_LANES;
  end

  always_ff @(posedge core_clk)
  begin
    if (loadAddr)
    begin
      addrHi_reg <= addr;
      selected_reg <= chipOn;
    end
  end

  sbs_burst_cnt #(
    .CW(2)
  ) u_cnt (
    .core_clk(core_clk),
    .load(loadAddr),
    .step(stepAddr),
    .startBits(addr[1:0]),
    .linearOrder(!burstOrder),
    .lowBits(lowBits)
  );

  assign curAddr = {addrHi_reg[AW-1:2], lowBits};

  // Cycle decode for the edge just taken
  always_comb
  begin
    cycle_next = sbs_pkg::SBS_IDLE;
    if (procStart)
      cycle_next = chipOn ? sbs_pkg::SBS_READ : sbs_pkg::SBS_IDLE;
    else if (ctrlStart)
      cycle_next = !chipOn ? sbs_pkg::SBS_IDLE
        : (wrLanes != `SBS_NO_LANES) ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
    else if (selected_reg && !standby_request)
      cycle_next = (wrLanes != `SBS_NO_LANES) ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cycle_reg <= sbs_pkg::SBS_IDLE;
    else
      cycle_reg <= cycle_next;
  end

  // Write data follows address by one edge; the array update runs on
  // its own with no further strobe from the master
  always_ff @(posedge core_clk)
  begin
    wrData_reg <= dataIn;
    if (cycle_reg == sbs_pkg::SBS_WRITE)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (wrLanes_reg[i])
          mem[wrAddr_reg][i*LW +: LW] <= dataIn[i*LW +: LW];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (cycle_next == sbs_pkg::SBS_WRITE)
    begin
      wrLanes_reg <= wrLanes;
      wrAddr_reg <= loadAddr ? addr : curAddr;
    end
    else
      wrLanes_reg <= `SBS_NO_LANES;
  end

  // Forward lanes being written this edge so an immediate read sees them
  always_comb
  begin
    flowData = mem[curAddr];
    if (cycle_reg == sbs_pkg::SBS_WRITE && wrAddr_reg == curAddr)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (wrLanes_reg[i])
          flowData[i*LW +: LW] = dataIn[i*LW +: LW];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    pipeData_reg <= flowData;
  end

  // Output validity: starts only after the access edge, ends on deselect
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      readValid_reg <= 1'b0;
      pipeValid_reg <= 1'b0;
      readPending_reg <= 1'b0;
      lastWasWrite_reg <= 1'b0;
    end
    else
    begin
      readValid_reg <= (cycle_next == sbs_pkg::SBS_READ);
      readPending_reg <= (cycle_next == sbs_pkg::SBS_READ);
      pipeValid_reg <= readPending_reg && readValid_reg;
      if (cycle_next == sbs_pkg::SBS_WRITE)
        lastWasWrite_reg <= 1'b1;
      else if (anyStrobe)
        lastWasWrite_reg <= 1'b0;
    end
  end

  always_comb
  begin
    if (latency_select)
      dataOut = pipeData_reg;
    else
      dataOut = flowData;
  end

  // Master keeps output drive off around write data, so no contention
  // guard is needed here beyond the write-cycle block
  assign dataOe_n = outDrive_n || standby_request || lastWasWrite_reg
    || !(latency_select ? pipeValid_reg : readValid_reg);

  property p_oe_off_after_write;
    @(posedge core_clk) disable iff (rst)
    (cycle_reg == sbs_pkg::SBS_WRITE) |-> dataOe_n;
  endproperty
  a_oe_off_after_write: assert property (p_oe_off_after_write) else $error("bus driven in write");

  property p_standby_off;
    @(posedge core_clk) disable iff (rst)
    standby_request |-> dataOe_n;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("bus driven in standby");

  // Flow-through empties at once; the pipelined stage still holds one word
  property p_deselect_off_flow;
    @(posedge core_clk) disable iff (rst)
    (ctrlStart && !chipOn && !latency_select) |=> dataOe_n;
  endproperty
  a_deselect_off_flow: assert property (p_deselect_off_flow) else $error("drive after deselect");

  property p_deselect_off_pipe;
    @(posedge core_clk) disable iff (rst)
    (ctrlStart && !chipOn && latency_select) |=> ##1 dataOe_n;
  endproperty
  a_deselect_off_pipe: assert property (p_deselect_off_pipe) else $error("drive after deselect");

  property p_first_edge_flow;
    @(posedge core_clk) disable iff (rst)
    (!latency_select && cycle_reg != sbs_pkg::SBS_READ) |-> dataOe_n;
  endproperty
  a_first_edge_flow: assert property (p_first_edge_flow) else $error("early flow drive");

  property p_first_edge_pipe;
    @(posedge core_clk) disable iff (rst)
    (latency_select && $past(cycle_reg) != sbs_pkg::SBS_READ) |-> dataOe_n;
  endproperty
  a_first_edge_pipe: assert property (p_first_edge_pipe) else $error("early pipe drive");

  property p_full_word;
    @(posedge core_clk) disable iff (rst)
    !full_word_write_n |-> (wrLanes == `SBS_FULL_LANES);
  endproperty
  a_full_word: assert property (p_full_word) else $error("full word write not full");

  property p_gate_high;
    @(posedge core_clk) disable iff (rst)
    (full_word_write_n && lane_write_gate_n) |-> (wrLanes == `SBS_NO_LANES);
  endproperty
  a_gate_high: assert property (p_gate_high) else $error("lane write without gate");

  property p_all_lanes;
    @(posedge core_clk) disable iff (rst)
    (full_word_write_n && !lane_write_gate_n && lane_write_n == 4'h0)
      |-> (wrLanes == `SBS_FULL_LANES);
  endproperty
  a_all_lanes: assert property (p_all_lanes) else $error("all lanes not full");

  property p_proc_read;
    @(posedge core_clk) disable iff (rst)
    (procStart && chipOn) |-> (cycle_next == sbs_pkg::SBS_READ);
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor strobe not a read");

  property p_addr_load;
    @(posedge core_clk) disable iff (rst)
    loadAddr |=> (addrHi_reg == $past(addr));
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address not loaded");

  property p_addr_hold;
    @(posedge core_clk) disable iff (rst)
    (!loadAddr && cycle_reg != sbs_pkg::SBS_IDLE) |=> $stable(addrHi_reg);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without strobe");

  property p_step_moves;
    @(posedge core_clk) disable iff (rst)
    stepAddr |=> (lowBits != $past(lowBits));
  endproperty
  a_step_moves: assert property (p_step_moves) else $error("burst step did not advance");

  // The order pin is static, so a change of it is not a step
  property p_no_step_hold;
    @(posedge core_clk) disable iff (rst)
    (!loadAddr && burst_step_n && cycle_reg != sbs_pkg::SBS_IDLE)
      |=> ($stable(lowBits) || $changed(burstOrder));
  endproperty
  a_no_step_hold: assert property (p_no_step_hold) else $error("counter moved in wait");

  property p_load_first;
    @(posedge core_clk) disable iff (rst)
    loadAddr |=> (lowBits == $past(addr[1:0]));
  endproperty
  a_load_first: assert property (p_load_first) else $error("first burst address wrong");

  property p_linear_step;
    @(posedge core_clk) disable iff (rst)
    (stepAddr && !burstOrder) |=> (lowBits == $past(lowBits) + 2'h1);
  endproperty
  a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

  property p_select_off;
    @(posedge core_clk) disable iff (rst)
    (loadAddr && !chipOn) |=> !selected_reg;
  endproperty
  a_select_off: assert property (p_select_off) else $error("selected without all selects");

  property p_write_start;
    @(posedge core_clk) disable iff (rst)
    (ctrlStart && !procStart && chipOn && wrLanes != `SBS_NO_LANES)
      |=> (cycle_reg == sbs_pkg::SBS_WRITE);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write cycle not started");

  property p_forward;
    @(posedge core_clk) disable iff (rst)
    (cycle_reg == sbs_pkg::SBS_WRITE && wrAddr_reg == curAddr && wrLanes_reg == `SBS_FULL_LANES)
      |-> (flowData == dataIn);
  endproperty
  a_forward: assert property (p_forward) else $error("written data not forwarded");

  property p_drive_off;
    @(posedge core_clk) disable iff (rst)
    outDrive_n |-> dataOe_n;
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("bus driven without enable");
endmodule

// ---- verilog/sbs_defines.svh ----
// Constants for the synchronous burst static memory core
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH
`define SBS_WORDS 32768
`define SBS_ADDR_W 15
`define SBS_DATA_W 32
`define SBS_LANES 4
`define SBS_LANE_W 8
`define SBS_CNT_W 2
`define SBS_FULL_LANES 4'hf
`define SBS_NO_LANES 4'h0
`endif

// ---- verilog/sbs_pkg.sv ----
// Types for the synchronous burst static memory core
package sbs_pkg;
  typedef enum logic [1:0]
  {
    SBS_IDLE = 2'b00,
    SBS_READ = 2'b01,
    SBS_WRITE = 2'b11
  } sbs_cycle_t;
endpackage

// ---- verilog/sbs_burst_cnt.sv ----
// Two-bit burst address generator, interleaved or linear order
`timescale 1ns/10ps
`include "sbs_defines.svh"
module sbs_burst_cnt #(
  parameter int CW = `SBS_CNT_W
) (
  input wire logic core_clk, // Clock
  input wire logic load, // Load start bits
  input wire logic step, // Advance count
  input wire logic [CW-1:0] startBits, // Low address bits of external address
  input wire logic linearOrder, // 1 selects linear order
  output logic [CW-1:0] lowBits // Current low address bits
);
  logic [CW-1:0] base_reg;
  logic [CW-1:0] count_reg;

  // No reset: counter is defined from the first load onward
  always_ff @(posedge core_clk)
  begin
    if (load)
    begin
      base_reg <= startBits;
      count_reg <= '0;
    end
    else if (step)
      count_reg <= count_reg + 1'b1;
  end

  // Order pin is static and acts combinationally
  always_comb
  begin
    if (linearOrder)
      lowBits = base_reg + count_reg;
    else
      lowBits = base_reg ^ count_reg;
  end
endmodule

// ---- dv/sbs_host_bus.sv ----
// Bus master side of the shared data bus, resolving the bus level
`timescale 1ns/10ps
module sbs_host_bus (
  input wire logic core_clk, // Clock
  input wire logic [31:0] dataOut, // Core read data
  input wire logic dataOe_n, // Core drive, low active
  input wire logic hostDrive, // Master drives write data
  input wire logic [31:0] hostData, // Master write data
  output logic [31:0] dataIn // Resolved bus level
);
  logic [31:0] lastReg;
  always_ff @(posedge core_clk)
  begin
    lastReg <= dataIn;
  end
  // A released bus shows the inverse of its last level, so stale data never passes
  always_comb
  begin
    if (dataOe_n == 1'b0)
      dataIn = dataOut;
    else if (hostDrive == 1'b1)
      dataIn = hostData;
    else
      dataIn = ~lastReg;
  end
endmodule

// ---- dv/sync_burst_sram_core_tb.sv ----
// Self-checking bench for the burst static memory core
`timescale 1ns/10ps
module sync_burst_sram_core_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [14:0] addr = 15'h0000;
  logic [31:0] dataIn, dataOut, hostData = 32'h00000000;
  logic dataOe_n, hostDrive = 1'b0, look = 1'b0;
  logic chipSel_n = 1'b0, secondarySel_n = 1'b0, secondary_select = 1'b1;
  logic proc_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b1, burst_step_n = 1'b1;
  logic [3:0] lane_write_n = 4'hf;
  logic lane_write_gate_n = 1'b1, full_word_write_n = 1'b1, outDrive_n = 1'b1;
  logic standby_request = 1'b0, latency_select = 1'b0, burstOrder = 1'b1;
  logic [31:0] mem [int];
  logic [32:0] expQ [$];
  logic [32:0] e;
  logic [31:0] rnd = 32'h1a0f;
  int err_total = 0, checked = 0;
  sbs_core uut (.core_clk(core_clk), .rst(rst), .addr(addr), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .chipSel_n(chipSel_n),
    .secondarySel_n(secondarySel_n), .secondary_select(secondary_select),
    .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_step_n(burst_step_n), .lane_write_n(lane_write_n),
    .lane_write_gate_n(lane_write_gate_n), .full_word_write_n(full_word_write_n),
    .outDrive_n(outDrive_n), .standby_request(standby_request),
    .latency_select(latency_select), .burstOrder(burstOrder));
  sbs_host_bus host (.core_clk(core_clk), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .hostDrive(hostDrive), .hostData(hostData), .dataIn(dataIn));
  initial
  begin
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Write data follows one edge after the controls; the master lets go at the next task
  task automatic wr(input logic [14:0] a, input logic [31:0] d, input logic gw,
    input logic gate, input logic [3:0] ln);
    logic [31:0] m;
    for (int i = 0; i < 4; i++)
      m[i*8 +: 8] = {8{gw == 1'b0 || (gate == 1'b0 && ln[i] == 1'b0)}};
    @(posedge core_clk);
    hostDrive <= 1'b0;
    addr <= a;
    ctrl_addr_strobe_n <= 1'b0;
    outDrive_n <= 1'b1;
    burst_step_n <= 1'b1;
    full_word_write_n <= gw;
    lane_write_gate_n <= gate;
    lane_write_n <= ln;
    @(posedge core_clk);
    ctrl_addr_strobe_n <= 1'b1;
    full_word_write_n <= 1'b1;
    lane_write_gate_n <= 1'b1;
    lane_write_n <= 4'hf;
    hostDrive <= 1'b1;
    hostData <= d;
    mem[a] = (mem[a] & ~m) | (d & m);
  endtask
  task automatic rd(input logic [14:0] a, input logic pipe, input logic lin, input int n,
    input logic proc, input logic sel, input logic zz);
    @(posedge core_clk);
    hostDrive <= 1'b0;
    latency_select <= pipe;
    burstOrder <= ~lin;
    addr <= a;
    proc_addr_strobe_n <= ~proc;
    ctrl_addr_strobe_n <= proc;
    secondary_select <= sel;
    outDrive_n <= 1'b0;
    standby_request <= zz;
    @(posedge core_clk);
    proc_addr_strobe_n <= 1'b1;
    ctrl_addr_strobe_n <= 1'b1;
    burst_step_n <= 1'b0;
    if (pipe)
      @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      expQ.push_back({!sel || zz, mem[{a[14:2], lin ? a[1:0] + i[1:0] : a[1:0] ^ i[1:0]}]});
      look <= 1'b1;
      @(posedge core_clk);
    end
    look <= 1'b0;
    burst_step_n <= 1'b1;
    secondary_select <= 1'b1;
    standby_request <= 1'b0;
  endtask
  always @(negedge core_clk)
  begin
    if (look && expQ.size() > 0)
    begin
      e = expQ.pop_front();
      checked++;
      if (e[32] ? dataOe_n !== 1'b1 : (dataOe_n !== 1'b0 || dataOut !== e[31:0]))
      begin
        err_total++;
        $display("BAD %0t read oe=%b data=%h expected %h", $time, dataOe_n, dataOut, e);
      end
    end
  end
  initial
  begin
    #100000;
    err_total++;
    results();
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++)
      wr(15'h0040 + k[14:0], xs(), 1'b0, 1'b1, 4'hf);
    rd(15'h0041, 1'b0, 1'b0, 4, 1'b0, 1'b1, 1'b0);
    rd(15'h0046, 1'b1, 1'b1, 4, 1'b1, 1'b1, 1'b0);
    rd(15'h0043, 1'b0, 1'b0, 2, 1'b1, 1'b1, 1'b0);
    wr(15'h0042, xs(), 1'b1, 1'b0, 4'ha);
    rd(15'h0042, 1'b0, 1'b0, 1, 1'b1, 1'b1, 1'b0);
    wr(15'h0043, xs(), 1'b1, 1'b1, 4'h0);
    wr(15'h0044, xs(), 1'b1, 1'b0, 4'h0);
    rd(15'h0043, 1'b1, 1'b0, 2, 1'b0, 1'b1, 1'b0);
    rd(15'h0044, 1'b1, 1'b0, 1, 1'b0, 1'b0, 1'b0);
    rd(15'h0044, 1'b0, 1'b0, 1, 1'b0, 1'b1, 1'b1);
    rd(15'h0044, 1'b0, 1'b0, 1, 1'b1, 1'b1, 1'b0);
    for (int k = 0; k < 6; k++)
      rd(15'h0040 + xs() % 8, xs() % 2, xs() % 2, 4, xs() % 2, 1'b1, 1'b0);
    results();
  end
endmodule
